// ---- cal_store_consts.svh ----
// constants for the calibration and configuration store
`ifndef CAL_STORE_CONSTS_SVH
`define CAL_STORE_CONSTS_SVH

// register byte offsets
`define OFS_CONFIG_WORD 12'h000
`define OFS_STORE_CTRL 12'h004
`define OFS_STORE_STATUS 12'h008
`define OFS_BIT_ADDR 12'h00C
`define OFS_BIT_DATA 12'h010
`define OFS_GAIN 12'h014
`define OFS_DAC_BASE 12'h020
`define OFS_STORE_BASE 12'h040

// store layout
`define STORE_WORDS 8
`define WORD_BITS 16
`define PAYLOAD_BITS 12
`define WORD_CONFIG 3'h0
`define WORD_DAC0 3'h1

// configuration fields
`define CFG_TC_SIGN 0
`define CFG_FINE_SIGN 1
`define CFG_GAIN_LSB 2
`define CFG_TEMP_SEL 5
`define CFG_RES_DIS 7
`define CFG_MAG_LSB 8
`define CFG_COARSE_SIGN 11

// gain law
`define GAIN_BASE 8'h29
`define GAIN_STEP 8'h1B

// store control bits
`define CTRL_ERASE 0
`define CTRL_WRITE 1
`define STATUS_REJECT 0

// refresh rate: 400 per second at 20 MHz
`define REFRESH_HZ 400
`define CLK_HZ 20000000
`define REFRESH_CYCLES (`CLK_HZ / `REFRESH_HZ)

`endif

// ---- cal_store_pkg.sv ----
// types for the calibration and configuration store
package cal_store_pkg;

typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
} apb_req_s;

typedef struct packed {
    logic [2:0] gain_code;
    logic [7:0] gain_value;
    logic coarse_offset_sign;
    logic [2:0] coarse_offset_mag;
    logic fine_offset_sign;
    logic offset_tempco_sign;
    logic ext_temp_select;
    logic internal_resistor_disable;
} cfg_decode_s;

typedef enum logic [1:0] {
    OP_IDLE,
    OP_ERASE,
    OP_WRITE
} store_op_e;

endpackage : cal_store_pkg

// ---- calibration_config_store.sv ----
// calibration store, working registers and configuration decode
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`include "cal_store_consts.svh"

module calibration_config_store #(
    parameter int REFRESH_CYCLES = `REFRESH_CYCLES
) (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire cal_store_pkg::apb_req_s apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // device pins
    input wire logic chip_select,
    input wire logic write_enable,
    input wire logic update_flag,
    output logic out_enable,
    // decoded controls
    output cal_store_pkg::cfg_decode_s cfg_decode,
    output logic [11:0] dac_offset,
    output logic [11:0] dac_offset_tc,
    output logic [11:0] dac_full_span,
    output logic [11:0] dac_full_span_tc
);
    import cal_store_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // storage
    // eight 16-bit words
    logic [`WORD_BITS-1:0] store_reg [`STORE_WORDS];
    logic [`WORD_BITS-1:0] store_next [`STORE_WORDS];

    logic [11:0] cfg_reg;
    logic [11:0] cfg_next;
    logic [11:0] dac_reg [4];
    logic [11:0] dac_next [4];

    logic [6:0] bit_addr_reg;
    logic [6:0] bit_addr_next;
    logic reject_reg;
    logic reject_next;
    logic cs_d_reg;
    logic cs_d_next;

    logic [31:0] refresh_cnt_reg;
    logic [31:0] refresh_cnt_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    store_op_e op;

    ////////////////////////////////////////////////////////////////////
    // functions
    function automatic logic [7:0] gain_of(
        input logic [2:0] code);
        gain_of = `GAIN_BASE + 8'(code) * `GAIN_STEP;
    endfunction : gain_of

    // word-aligned window of count registers from base
    function automatic logic in_window(
        input logic [11:0] addr,
        input logic [11:0] base,
        input int count);
        logic [11:0] top;
        top = base + 12'(4 * count);
        in_window = addr >= base && addr < top && addr[1:0] == 2'h0;
    endfunction : in_window

    ////////////////////////////////////////////////////////////////////
    // bus decode
    wire access = apb_req.psel && apb_req.penable;
    wire wr = access && apb_req.pwrite;
    wire rd_setup = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
    wire [11:0] a = apb_req.paddr;

    wire hit_cfg = a == `OFS_CONFIG_WORD;
    wire hit_ctrl = a == `OFS_STORE_CTRL;
    wire hit_stat = a == `OFS_STORE_STATUS;
    wire hit_addr = a == `OFS_BIT_ADDR;
    wire hit_data = a == `OFS_BIT_DATA;
    wire hit_gain = a == `OFS_GAIN;
    wire hit_dac = in_window(a, `OFS_DAC_BASE, 4);
    wire hit_store = in_window(a, `OFS_STORE_BASE, `STORE_WORDS);
    wire mapped = hit_cfg | hit_ctrl
        | hit_stat | hit_addr
        | hit_data | hit_gain
        | hit_dac | hit_store;

    wire [2:0] word_sel = bit_addr_reg[6:4];
    wire [3:0] bit_sel = bit_addr_reg[3:0];
    wire [1:0] dac_sel = a[3:2];
    wire [2:0] store_sel = a[4:2];

    ////////////////////////////////////////////////////////////////////
    // programming commands
    // programming only while write enable is high
    wire prog_req = wr && hit_ctrl;
    wire prog_ok = write_enable;
    assign op = !prog_req ? OP_IDLE :
        apb_req.pwdata[`CTRL_ERASE] ? OP_ERASE :
        apb_req.pwdata[`CTRL_WRITE] ? OP_WRITE :
        OP_IDLE;

    wire reject_set = op != OP_IDLE && !prog_ok;
    wire reject_clr = wr && hit_stat && apb_req.pwdata[`STATUS_REJECT];
    wire addr_load = wr && hit_addr;

    ////////////////////////////////////////////////////////////////////
    // reload sources
    // reload on rising chip select unless update flag set
    wire cs_rise = chip_select && !cs_d_reg && !update_flag;
    wire count_done = refresh_cnt_reg >= 32'(REFRESH_CYCLES - 1);
    wire tick = write_enable && count_done;
    wire reload = cs_rise || tick;

    ////////////////////////////////////////////////////////////////////
    // store array next value
    always_comb begin
        for (int i = 0; i < `STORE_WORDS; i++) begin
            store_next[i] = store_reg[i];
        end
        case (op)
            OP_ERASE: begin
                if (prog_ok) begin
                    for (int i = 0; i < `STORE_WORDS; i++) begin
                        store_next[i] = 16'h0000;
                    end
                end
            end
            OP_WRITE: begin
                if (prog_ok) begin
                    store_next[word_sel][bit_sel] = 1'b1;
                end
            end
            OP_IDLE: begin
            end
            default: begin
            end
        endcase
    end

    // store array
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `STORE_WORDS; i++) begin
                store_reg[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < `STORE_WORDS; i++) begin
                store_reg[i] <= store_next[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bit address
    assign bit_addr_next = addr_load ? apb_req.pwdata[6:0] : bit_addr_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_addr_reg <= 7'h00;
        end else begin
            bit_addr_reg <= bit_addr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reject flag: sticky, a new reject wins over a clear
    assign reject_next = reject_set ? 1'b1 :
        reject_clr ? 1'b0 : reject_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reject_reg <= 1'b0;
        end else begin
            reject_reg <= reject_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // chip select history, reset high so that a select held through
    // reset does not look like a rising edge
    assign cs_d_next = chip_select;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_d_reg <= 1'b1;
        end else begin
            cs_d_reg <= cs_d_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // refresh timer
    // timer cleared and frozen while write enable low
    assign refresh_cnt_next = (!write_enable || tick) ? 32'h0000_0000 :
        refresh_cnt_reg + 32'h0000_0001;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refresh_cnt_reg <= 32'h0000_0000;
        end else begin
            refresh_cnt_reg <= refresh_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // working registers
    // loaded only on reload, held otherwise
    assign cfg_next = reload ? store_reg[`WORD_CONFIG][11:0] : cfg_reg;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            dac_next[i] = reload ?
                store_reg[3'(`WORD_DAC0 + i)][11:0] : dac_reg[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= 12'h000;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                dac_reg[i] <= 12'h000;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                dac_reg[i] <= dac_next[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data
    wire [31:0] rd_cfg = {20'h00000, cfg_reg};
    wire [31:0] rd_stat = {29'h0, write_enable, chip_select, reject_reg};
    wire [31:0] rd_addr = {25'h0, bit_addr_reg};
    wire [31:0] rd_data = {31'h0, store_reg[word_sel][bit_sel]};
    wire [31:0] rd_gain = {24'h0, cfg_decode.gain_value};
    wire [31:0] rd_dac = {20'h00000, dac_reg[dac_sel]};
    wire [31:0] rd_store = {16'h0000, store_reg[store_sel]};

    wire [31:0] rd_mux =
        hit_cfg ? rd_cfg :
        hit_stat ? rd_stat :
        hit_addr ? rd_addr :
        hit_data ? rd_data :
        hit_gain ? rd_gain :
        hit_dac ? rd_dac :
        hit_store ? rd_store : 32'h0000_0000;

    // captured in the setup phase, held until the next read
    assign prdata_next = rd_setup ? rd_mux : prdata_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else begin
            prdata_reg <= prdata_next;
        end
    end

    assign prdata = prdata_reg;
    // zero wait states: every access phase completes at once
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    ////////////////////////////////////////////////////////////////////
    // configuration decode
    // fields from working configuration word
    wire [2:0] gain_code = cfg_reg[`CFG_GAIN_LSB +: 3];
    wire [7:0] gain_value = gain_of(gain_code);
    wire coarse_sign = cfg_reg[`CFG_COARSE_SIGN];
    wire [2:0] coarse_mag = cfg_reg[`CFG_MAG_LSB +: 3];
    wire fine_sign = cfg_reg[`CFG_FINE_SIGN];
    wire tempco_sign = cfg_reg[`CFG_TC_SIGN];
    wire temp_select = cfg_reg[`CFG_TEMP_SEL];
    wire resistor_disable = cfg_reg[`CFG_RES_DIS];

    assign cfg_decode.gain_code = gain_code;
    assign cfg_decode.gain_value = gain_value;
    assign cfg_decode.coarse_offset_sign = coarse_sign;
    assign cfg_decode.coarse_offset_mag = coarse_mag;
    assign cfg_decode.fine_offset_sign = fine_sign;
    assign cfg_decode.offset_tempco_sign = tempco_sign;
    assign cfg_decode.ext_temp_select = temp_select;
    assign cfg_decode.internal_resistor_disable = resistor_disable;

    ////////////////////////////////////////////////////////////////////
    // DAC coefficient outputs
    // one working register per DAC
    assign dac_offset = dac_reg[0];
    assign dac_offset_tc = dac_reg[1];
    assign dac_full_span = dac_reg[2];
    assign dac_full_span_tc = dac_reg[3];
    // words 5 to 7 hold user data only
    // nothing reads them except the store and bit data read-back

    ////////////////////////////////////////////////////////////////////
    // analog output control
    // output driven only while chip select high
    assign out_enable = chip_select;

endmodule : calibration_config_store

// ---- calibration_config_store_props.sv ----
// port checker for the calibration store, bound to its top module
`timescale 1ns/100ps
`include "cal_store_consts.svh"
module calibration_config_store_chk #(
    parameter int REFRESH_CYCLES = 20
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire cal_store_pkg::apb_req_s apb_req,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins and controls
    input wire logic chip_select,
    input wire logic write_enable,
    input wire logic update_flag,
    input wire logic out_enable,
    input wire cal_store_pkg::cfg_decode_s cfg_decode,
    input wire logic [11:0] dac_offset,
    input wire logic [11:0] dac_offset_tc,
    input wire logic [11:0] dac_full_span,
    input wire logic [11:0] dac_full_span_tc
);
    import cal_store_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic rd_acc = apb_req.psel && apb_req.penable && !apb_req.pwrite;
    wire logic quiet_rd = rd_acc && !write_enable;
    // no refresh and no chip select edge lately
    sequence frozen;
        !write_enable && !$past(write_enable) && !$past(write_enable, 2)
            && $stable(chip_select) && chip_select == $past(chip_select, 2)
            && chip_select == $past(chip_select, 3);
    endsequence
    a_out_follows_cs: assert property (out_enable == chip_select)
        else $error("output enable differs from chip select");
    a_gain_law: assert property (cfg_decode.gain_value ==
        8'h29 + 8'h1B * cfg_decode.gain_code) else $error("gain value wrong");
    a_cfg_held: assert property (frozen |=> $stable(cfg_decode))
        else $error("decode moved without reload");
    a_dac_held: assert property (frozen |=> $stable({dac_offset,
        dac_offset_tc, dac_full_span, dac_full_span_tc}))
        else $error("dac value moved without reload");
    a_coarse_gain_map: assert property (quiet_rd
        && apb_req.paddr == `OFS_CONFIG_WORD |-> prdata[11:2] ==
        {cfg_decode.coarse_offset_sign, cfg_decode.coarse_offset_mag,
        cfg_decode.internal_resistor_disable, 1'b0,
        cfg_decode.ext_temp_select, cfg_decode.gain_code})
        else $error("config word and decode disagree");
    a_sign_bits_map: assert property (quiet_rd
        && apb_req.paddr == `OFS_CONFIG_WORD |-> prdata[1:0] ==
        {cfg_decode.fine_offset_sign, cfg_decode.offset_tempco_sign})
        else $error("sign bits and decode disagree");
    a_dac_word_map: assert property (quiet_rd
        && apb_req.paddr == `OFS_DAC_BASE |-> prdata == {20'h00000, dac_offset})
        else $error("offset dac and its register disagree");
    a_store_top_zero: assert property (rd_acc
        && apb_req.paddr[11:5] == 7'h02 |-> prdata[31:16] == 16'h0000)
        else $error("store word wider than 16 bits");
    c_unmapped: cover property (rd_acc && pslverr);
    c_cs_reload: cover property ($rose(chip_select) && !update_flag);
    c_locked_write: cover property (!write_enable && apb_req.pwrite && pready);
endmodule : calibration_config_store_chk
bind calibration_config_store calibration_config_store_chk #(
    .REFRESH_CYCLES(REFRESH_CYCLES)) calibration_config_store_chk_i (.pclk,
    .presetn, .apb_req, .prdata, .pready, .pslverr, .chip_select,
    .write_enable, .update_flag, .out_enable, .cfg_decode, .dac_offset,
    .dac_offset_tc, .dac_full_span, .dac_full_span_tc);

// ---- host_model.sv ----
// host test computer model: apb master and device pins
`timescale 1ns/100ps
`include "cal_store_consts.svh"
module host_model (
    // clock and apb
    input wire logic pclk,
    output cal_store_pkg::apb_req_s apb_req,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // device pins
    output logic chip_select,
    output logic write_enable,
    output logic update_flag
);
    import cal_store_pkg::*;
    initial begin
        apb_req = '0;
        {chip_select, write_enable, update_flag} = 3'h6;
    end
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge pclk);
        apb_req <= '{a, 1'b1, 1'b0, w, d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : xfer
    task automatic pins(input logic [2:0] v);
        @(posedge pclk);
        {chip_select, write_enable, update_flag} <= v;
    endtask : pins
    task automatic burn(input logic [127:0] img);
        logic [31:0] q;
        logic e;
        for (int n = 0; n < 128; n++) begin
            if (img[n]) begin
                xfer(1'b1, `OFS_BIT_ADDR, 32'(n), q, e);
                xfer(1'b1, `OFS_STORE_CTRL, 32'h2, q, e);
            end
        end
    endtask : burn
endmodule : host_model

// ---- calibration_config_store_tb_top.sv ----
// testbench: programs the store over apb and checks the decoded controls
`timescale 1ns/100ps
`include "cal_store_consts.svh"
module calibration_config_store_tb_top;
    import cal_store_pkg::*;
    localparam int refresh = 1000;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    apb_req_s apb_req;
    logic [31:0] prdata, q;
    logic pready, pslverr, e, chip_select, write_enable, update_flag;
    logic out_enable;
    cfg_decode_s cfg_decode, x;
    logic [11:0] dac_offset, dac_offset_tc, dac_full_span, dac_full_span_tc;
    logic [11:0] cf;
    logic [127:0] img;
    logic [3:0] rsv [8];
    int errors = 0;
    int n_checks = 0;
    always #25 pclk = ~pclk;
    calibration_config_store #(.REFRESH_CYCLES(refresh))
        calibration_config_store_i (.pclk, .presetn, .apb_req, .prdata,
        .pready, .pslverr, .chip_select, .write_enable, .update_flag,
        .out_enable, .cfg_decode, .dac_offset, .dac_offset_tc,
        .dac_full_span, .dac_full_span_tc);
    host_model host_model_i (.pclk, .apb_req, .prdata, .pready, .pslverr,
        .chip_select, .write_enable, .update_flag);
    task automatic chk(input string s, input logic [31:0] a, b);
        n_checks++;
        if (a !== b) begin
            errors++;
            $display("mismatch %s expected %h seen %h", s, a, b);
        end
    endtask : chk
    task automatic rw(input logic w, input logic [11:0] a, input int d);
        host_model_i.xfer(w, a, 32'(d), q, e);
    endtask : rw
    function automatic cfg_decode_s dec(input logic [11:0] c);
        return '{c[4:2], 8'h29 + 8'h1B * c[4:2], c[11], c[10:8], c[1], c[0],
            c[5], c[7]};
    endfunction : dec
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            cf = {~c[0], c[2:0], c[1], 1'b0, c[2], c[2:0], c[0], c[1]};
            for (int w = 0; w < 8; w++) begin
                rw(1'b0, `OFS_STORE_BASE + 12'(4 * w), 0);
                rsv[w] = (c == 0) ? 4'(w + 8) : q[15:12];
            end
            rw(1'b1, `OFS_STORE_CTRL, 1);
            img = {112'h0, rsv[0], cf};
            for (int w = 0; w < 8; w++) begin
                rw(1'b0, `OFS_STORE_BASE + 12'(4 * w), 0);
                chk("erased word", 32'h0, q);
                if (w > 0) img[16*w +: 16] = {rsv[w], 12'(c*256 + w*17)};
            end
            host_model_i.burn(img);
            for (int w = 0; w < 8; w++) begin
                rw(1'b0, `OFS_STORE_BASE + 12'(4 * w), 0);
                chk("store word", 32'(img[16*w +: 16]), q);
            end
            rw(1'b1, `OFS_BIT_ADDR, 16 * c + 7);
            rw(1'b0, `OFS_BIT_DATA, 0);
            chk("store bit", 32'(img[16 * c + 7]), q);
            repeat (refresh + 4) @(posedge pclk);
            chk("decode", 32'(dec(cf)), 32'(cfg_decode));
            chk("dac a", 32'({img[27:16], img[43:32]}),
                32'({dac_offset, dac_offset_tc}));
            chk("dac b", 32'({img[59:48], img[75:64]}),
                32'({dac_full_span, dac_full_span_tc}));
            $display("gain round %0d done", c);
        end
        x = cfg_decode;
        host_model_i.pins(3'h4);
        host_model_i.pins(3'h6);
        rw(1'b1, `OFS_STORE_CTRL, 1);
        host_model_i.burn({112'h0, 16'h89B6});
        host_model_i.pins(3'h4);
        repeat (refresh + 4) @(posedge pclk);
        chk("held", 32'(x), 32'(cfg_decode));
        host_model_i.pins(3'h1);
        repeat (3) @(posedge pclk);
        chk("output off", 32'h0, 32'(out_enable));
        host_model_i.pins(3'h5);
        repeat (3) @(posedge pclk);
        chk("no reload", 32'(x), 32'(cfg_decode));
        host_model_i.pins(3'h0);
        host_model_i.pins(3'h4);
        repeat (3) @(posedge pclk);
        chk("reload", 32'(dec(12'h9B6)), 32'(cfg_decode));
        rw(1'b0, `OFS_CONFIG_WORD, 0);
        chk("config", 32'h9B6, q);
        rw(1'b0, `OFS_DAC_BASE, 0);
        chk("dac zero", 32'h0, q);
        rw(1'b1, `OFS_STORE_CTRL, 1);
        rw(1'b0, `OFS_STORE_STATUS, 0);
        chk("reject", 32'h1, q & 32'h1);
        rw(1'b0, `OFS_STORE_BASE, 0);
        chk("kept", 32'h89B6, q);
        rw(1'b0, 12'h018, 0);
        chk("unmapped", 32'h1, {q[30:0], e});
        $display("lock and reload test done");
        close_out();
    end
    initial begin
        #(50 * 40000);
        errors++;
        close_out();
    end
endmodule : calibration_config_store_tb_top
